/* File: rtl/analog_trigger_detect.sv */
// shared analog trigger detector: comparator sync and five trigger conditions
`timescale 1ns/100ps
`default_nettype none
module analog_trigger_detect (
    input wire logic clk_sys, // board clock
    input wire logic reset, // synchronous, active high
    trig_detect_if.detector det // condition in, event out
);
    typedef struct packed {
        logic [2:0] s_lo;
        logic [2:0] s_hi;
        logic lo;
        logic hi;
        logic lvl_q;
        trig_route_pkg::arm_t arm;
        logic evt;
    } det_state_t;

    det_state_t st, next_st;
    logic lvl;

    always_comb begin
        next_st = st;
        next_st.s_lo = {st.s_lo[1:0], det.cmp_below_low};
        next_st.s_hi = {st.s_hi[1:0], det.cmp_above_high};
        if (st.s_lo[1] == st.s_lo[2]) begin
            next_st.lo = st.s_lo[2];
        end
        if (st.s_hi[1] == st.s_hi[2]) begin
            next_st.hi = st.s_hi[2];
        end
        next_st.evt = 1'b0;
        lvl = 1'b0;
        unique case (det.cond)
            trig_route_pkg::COND_BELOW_LOW: lvl = st.lo;
            trig_route_pkg::COND_ABOVE_HIGH: lvl = st.hi;
            trig_route_pkg::COND_INSIDE: lvl = !st.lo && !st.hi;
            trig_route_pkg::COND_HIGH_HYST: lvl = st.hi;
            trig_route_pkg::COND_LOW_HYST: lvl = st.lo;
            default: lvl = 1'b0;
        endcase
        next_st.lvl_q = lvl;
        unique case (det.cond)
            trig_route_pkg::COND_HIGH_HYST: begin
                if (st.arm == trig_route_pkg::ARMED && st.hi) begin
                    next_st.evt = 1'b1;
                    next_st.arm = trig_route_pkg::DISARMED;
                end else if (st.lo) begin
                    next_st.arm = trig_route_pkg::ARMED;
                end
            end
            trig_route_pkg::COND_LOW_HYST: begin
                if (st.arm == trig_route_pkg::ARMED && st.lo) begin
                    next_st.evt = 1'b1;
                    next_st.arm = trig_route_pkg::DISARMED;
                end else if (st.hi) begin
                    next_st.arm = trig_route_pkg::ARMED;
                end
            end
            default: begin
                next_st.evt = lvl && !st.lvl_q;
                next_st.arm = trig_route_pkg::DISARMED;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign det.event_pulse = st.evt;
    assign det.level = st.lvl_q;
    assign det.armed = st.arm == trig_route_pkg::ARMED;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    property p_single_pulse;
        st.evt |=> !st.evt;
    endproperty
    a_single_pulse: assert property (p_single_pulse)
        else $error("trigger event longer than one cycle");

    property p_below_low;
        (det.cond == trig_route_pkg::COND_BELOW_LOW && $stable(det.cond) && st.evt)
            |-> $past(st.lo) && !$past(st.lvl_q);
    endproperty
    a_below_low: assert property (p_below_low)
        else $error("below-low event without a fresh low crossing");

    property p_above_high;
        (det.cond == trig_route_pkg::COND_ABOVE_HIGH && $stable(det.cond) && st.evt)
            |-> $past(st.hi) && !$past(st.lvl_q);
    endproperty
    a_above_high: assert property (p_above_high)
        else $error("above-high event without a fresh high crossing");

    property p_no_rearm;
        (det.cond inside {trig_route_pkg::COND_HIGH_HYST, trig_route_pkg::COND_LOW_HYST}
            && st.arm == trig_route_pkg::DISARMED) |=> !st.evt;
    endproperty
    a_no_rearm: assert property (p_no_rearm)
        else $error("hysteresis fired while disarmed");

    property p_sync_lat;
        (det.cmp_above_high && !st.hi)[*4] |=> st.hi;
    endproperty
    a_sync_lat: assert property (p_sync_lat)
        else $error("comparator level not taken after sync");

    c_hyst_event: cover property (det.cond == trig_route_pkg::COND_HIGH_HYST && st.evt);
    c_inside_event: cover property (det.cond == trig_route_pkg::COND_INSIDE && st.evt);
endmodule
`default_nettype wire

/* File: rtl/trigger_timing_route.sv */
// trigger source select, software triggers and timing signal routing
//
// The register addresses and the plain strobed port were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module trigger_timing_route (
    input wire logic clk_sys, // board clock, 250 MHz
    input wire logic reset, // synchronous, active high
    input wire logic [7:0] addr, // register byte address
    input wire logic [31:0] wdata, // register write data
    input wire logic wr, // write strobe
    input wire logic rd, // read strobe
    output logic [31:0] rdata, // read data, cycle after rd
    input wire logic cmp_below_low, // comparator: input under lower level
    input wire logic cmp_above_high, // comparator: input over upper level
    input wire logic [1:0] aux_function_inputs, // aux timing pins
    input wire logic [6:0] internal_timing, // on-board timing sources
    input wire logic [6:0] board_sync_bus_in, // sync bus pin levels
    output logic [6:0] board_sync_bus_out, // sync bus drive value
    output logic [6:0] board_sync_bus_oe_n, // sync bus enable, low drives
    output logic [6:0] timing_sig, // selected timing signals
    output logic conv_in_trigger, // conversion-in trigger pulse
    output logic conv_out_trigger, // conversion-out trigger pulse
    output logic analog_src_sel, // 0 pin level, 1 converter input
    output logic [7:0] low_level_code, // lower threshold DAC code
    output logic [7:0] high_level_code // upper threshold DAC code
);
    typedef struct packed {
        trig_route_pkg::trig_src_t in_src;
        trig_route_pkg::trig_src_t out_src;
        logic ana_src;
        trig_route_pkg::cond_t cond;
        logic [7:0] lo_code;
        logic [7:0] hi_code;
        logic [6:0][1:0] tsel;
        logic [6:0] master;
        logic [1:0] a1;
        logic [1:0] a2;
        logic [1:0] a3;
        logic [1:0] af;
        logic [6:0] b1;
        logic [6:0] b2;
        logic [6:0] b3;
        logic [6:0] bf;
        logic dig_q;
        logic in_trig;
        logic out_trig;
        logic [6:0] timing;
        logic [6:0] bus_out;
        logic [6:0] bus_oe_n;
        logic [31:0] rdata;
    } route_state_t;

    route_state_t st, next_st, rst_st;
    trig_detect_if tdi();
    logic sw_in;
    logic sw_out;
    logic dig_evt;
    logic [6:0] own_sig;

    analog_trigger_detect u_detect (
        .clk_sys(clk_sys),
        .reset(reset),
        .det(tdi.detector)
    );

    // one detector shared by both processes
    assign tdi.cond = st.cond;
    assign tdi.cmp_below_low = cmp_below_low;
    assign tdi.cmp_above_high = cmp_above_high;

    always_comb begin
        rst_st = '0;
        rst_st.in_src = trig_route_pkg::RST_SRC;
        rst_st.out_src = trig_route_pkg::RST_SRC;
        rst_st.ana_src = trig_route_pkg::RST_ANA_SRC;
        rst_st.cond = trig_route_pkg::RST_COND;
        rst_st.lo_code = trig_route_pkg::RST_LEVEL;
        rst_st.hi_code = trig_route_pkg::RST_LEVEL;
        rst_st.tsel = {7{trig_route_pkg::TSEL_INTERNAL}};
        rst_st.master = trig_route_pkg::RST_MASTER;
        rst_st.bus_oe_n = 7'h7F;
    end

    function automatic logic fire(trig_route_pkg::trig_src_t src, logic sw,
        logic ana, logic dig);
        logic f;
        f = 1'b0;
        unique case (src)
            trig_route_pkg::TSRC_SOFTWARE: f = sw;
            trig_route_pkg::TSRC_ANALOG: f = ana;
            trig_route_pkg::TSRC_DIGITAL: f = dig;
            default: f = 1'b0;
        endcase
        return f;
    endfunction

    always_comb begin
        next_st = st;
        sw_in = 1'b0;
        sw_out = 1'b0;
        own_sig = '0;
        // pins: three flops, a change counts once stages 2 and 3 agree
        next_st.a1 = aux_function_inputs;
        next_st.a2 = st.a1;
        next_st.a3 = st.a2;
        next_st.af = (st.a2 & ~(st.a2 ^ st.a3)) | (st.af & (st.a2 ^ st.a3));
        next_st.b1 = board_sync_bus_in;
        next_st.b2 = st.b1;
        next_st.b3 = st.b2;
        next_st.bf = (st.b2 & ~(st.b2 ^ st.b3)) | (st.bf & (st.b2 ^ st.b3));
        next_st.dig_q = st.af[trig_route_pkg::DIG_TRIG_AUX];
        dig_evt = st.af[trig_route_pkg::DIG_TRIG_AUX] && !st.dig_q;
        if (wr) begin
            unique case (addr)
                trig_route_pkg::OFS_TRIG_CTRL: begin
                    next_st.in_src = trig_route_pkg::trig_src_t'(
                        wdata[trig_route_pkg::TC_IN_SRC_LSB +: 2]);
                    next_st.out_src = trig_route_pkg::trig_src_t'(
                        wdata[trig_route_pkg::TC_OUT_SRC_LSB +: 2]);
                    next_st.ana_src = wdata[trig_route_pkg::TC_ANA_SRC_BIT];
                    next_st.cond = trig_route_pkg::cond_t'(
                        wdata[trig_route_pkg::TC_COND_LSB +: 3]);
                end
                trig_route_pkg::OFS_THRESH: begin
                    // codes go straight to the level DACs
                    next_st.lo_code = wdata[trig_route_pkg::TH_LOW_LSB +: 8];
                    next_st.hi_code = wdata[trig_route_pkg::TH_HIGH_LSB +: 8];
                end
                trig_route_pkg::OFS_SW_TRIG: begin
                    sw_in = wdata[trig_route_pkg::SW_IN_BIT];
                    sw_out = wdata[trig_route_pkg::SW_OUT_BIT];
                end
                trig_route_pkg::OFS_TIMING_SEL: next_st.tsel = wdata[13:0];
                trig_route_pkg::OFS_MASTER: next_st.master = wdata[6:0];
                default: next_st.master = st.master;
            endcase
        end
        next_st.in_trig = fire(st.in_src, sw_in, tdi.event_pulse, dig_evt);
        next_st.out_trig = fire(st.out_src, sw_out, tdi.event_pulse, dig_evt);
        for (int i = 0; i < trig_route_pkg::N_TIMING; i++) begin
            unique case (trig_route_pkg::tsel_t'(st.tsel[i]))
                trig_route_pkg::TSEL_INTERNAL: own_sig[i] = internal_timing[i];
                trig_route_pkg::TSEL_AUX0: own_sig[i] = st.af[0];
                trig_route_pkg::TSEL_AUX1: own_sig[i] = st.af[1];
                trig_route_pkg::TSEL_BUS: own_sig[i] = internal_timing[i];
            endcase
            // a master never listens to its own bus line
            next_st.timing[i] = (st.tsel[i] == trig_route_pkg::TSEL_BUS && !st.master[i])
                ? st.bf[i] : own_sig[i];
        end
        // master drives its own signal out
        next_st.bus_out = own_sig & st.master;
        next_st.bus_oe_n = ~st.master;
        next_st.rdata = '0;
        if (rd) begin
            unique case (addr)
                trig_route_pkg::OFS_TRIG_CTRL: begin
                    next_st.rdata[trig_route_pkg::TC_IN_SRC_LSB +: 2] = st.in_src;
                    next_st.rdata[trig_route_pkg::TC_OUT_SRC_LSB +: 2] = st.out_src;
                    next_st.rdata[trig_route_pkg::TC_ANA_SRC_BIT] = st.ana_src;
                    next_st.rdata[trig_route_pkg::TC_COND_LSB +: 3] = st.cond;
                end
                trig_route_pkg::OFS_THRESH: begin
                    next_st.rdata[trig_route_pkg::TH_LOW_LSB +: 8] = st.lo_code;
                    next_st.rdata[trig_route_pkg::TH_HIGH_LSB +: 8] = st.hi_code;
                end
                trig_route_pkg::OFS_TIMING_SEL: next_st.rdata[13:0] = st.tsel;
                trig_route_pkg::OFS_MASTER: next_st.rdata[6:0] = st.master;
                trig_route_pkg::OFS_STATUS: begin
                    next_st.rdata[trig_route_pkg::ST_LEVEL_BIT] = tdi.level;
                    next_st.rdata[trig_route_pkg::ST_ARMED_BIT] = tdi.armed;
                    next_st.rdata[trig_route_pkg::ST_TIMING_LSB +: 7] = st.timing;
                    next_st.rdata[trig_route_pkg::ST_BUS_LSB +: 7] = st.bf;
                end
                default: next_st.rdata = '0;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            st <= rst_st;
        end else begin
            st <= next_st;
        end
    end

    assign rdata = st.rdata;
    assign board_sync_bus_out = st.bus_out;
    assign board_sync_bus_oe_n = st.bus_oe_n;
    assign timing_sig = st.timing;
    assign conv_in_trigger = st.in_trig;
    assign conv_out_trigger = st.out_trig;
    assign analog_src_sel = st.ana_src;
    assign low_level_code = st.lo_code;
    assign high_level_code = st.hi_code;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    property p_sw_trig;
        (wr && addr == trig_route_pkg::OFS_SW_TRIG && wdata[0]
            && st.in_src == trig_route_pkg::TSRC_SOFTWARE) |=> conv_in_trigger;
    endproperty
    a_sw_trig: assert property (p_sw_trig)
        else $error("software trigger did not fire next cycle");

    property p_sw_indep;
        (wr && addr == trig_route_pkg::OFS_SW_TRIG && wdata[1:0] == 2'h2
            && st.in_src == trig_route_pkg::TSRC_SOFTWARE) |=> !conv_in_trigger;
    endproperty
    a_sw_indep: assert property (p_sw_indep)
        else $error("out command fired the in trigger");

    property p_shared_analog;
        (st.in_src == trig_route_pkg::TSRC_ANALOG
            && st.out_src == trig_route_pkg::TSRC_ANALOG && tdi.event_pulse)
            |=> conv_in_trigger && conv_out_trigger;
    endproperty
    a_shared_analog: assert property (p_shared_analog)
        else $error("analog event not seen by both processes");

    property p_src_write;
        (wr && addr == trig_route_pkg::OFS_TRIG_CTRL)
            |=> st.in_src == $past(wdata[1:0]) && analog_src_sel == $past(wdata[4]);
    endproperty
    a_src_write: assert property (p_src_write)
        else $error("trigger control write not taken");

    property p_master_drive;
        (st.master[0] && st.tsel[0] == trig_route_pkg::TSEL_INTERNAL)
            |=> !board_sync_bus_oe_n[0] && board_sync_bus_out[0] == $past(internal_timing[0]);
    endproperty
    a_master_drive: assert property (p_master_drive)
        else $error("master not driving its timing signal");

    property p_slave_take;
        (!st.master[1] && st.tsel[1] == trig_route_pkg::TSEL_BUS)
            |=> timing_sig[1] == $past(st.bf[1]) && board_sync_bus_oe_n[1];
    endproperty
    a_slave_take: assert property (p_slave_take)
        else $error("slave not following the sync bus");

    property p_reset_state;
        disable iff (1'b0) reset |=> board_sync_bus_oe_n == 7'h7F && st.tsel == '0;
    endproperty
    a_reset_state: assert property (p_reset_state)
        else $error("reset left a selection or bus driver active");

    c_analog_in: cover property (conv_in_trigger && st.in_src == trig_route_pkg::TSRC_ANALOG);
    c_master: cover property (!board_sync_bus_oe_n[0] && board_sync_bus_out[0]);
    c_dig_out: cover property (conv_out_trigger && st.out_src == trig_route_pkg::TSRC_DIGITAL);
endmodule
`default_nettype wire

/* File: shared/trig_detect_if.sv */
// link between the route logic and the analog trigger detector
`timescale 1ns/100ps
`default_nettype none
interface trig_detect_if;
    trig_route_pkg::cond_t cond;
    logic cmp_below_low;
    logic cmp_above_high;
    logic event_pulse;
    logic level;
    logic armed;
    modport detector (input cond, cmp_below_low, cmp_above_high,
        output event_pulse, level, armed);
    modport control (output cond, cmp_below_low, cmp_above_high,
        input event_pulse, level, armed);
endinterface
`default_nettype wire

/* File: shared/trig_route_pkg.sv */
// constants and types shared by the trigger select and timing route block
`default_nettype none
package trig_route_pkg;
    localparam int N_TIMING = 7;
    localparam int N_AUX = 2;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    // register byte offsets
    localparam logic [7:0] OFS_TRIG_CTRL = 8'h00;
    localparam logic [7:0] OFS_THRESH = 8'h04;
    localparam logic [7:0] OFS_SW_TRIG = 8'h08;
    localparam logic [7:0] OFS_TIMING_SEL = 8'h0C;
    localparam logic [7:0] OFS_MASTER = 8'h10;
    localparam logic [7:0] OFS_STATUS = 8'h14;
    // field positions
    localparam int TC_IN_SRC_LSB = 0;
    localparam int TC_OUT_SRC_LSB = 2;
    localparam int TC_ANA_SRC_BIT = 4;
    localparam int TC_COND_LSB = 5;
    localparam int TH_LOW_LSB = 0;
    localparam int TH_HIGH_LSB = 8;
    localparam int SW_IN_BIT = 0;
    localparam int SW_OUT_BIT = 1;
    localparam int ST_LEVEL_BIT = 0;
    localparam int ST_ARMED_BIT = 1;
    localparam int ST_TIMING_LSB = 2;
    localparam int ST_BUS_LSB = 9;
    localparam int DIG_TRIG_AUX = 0;
    // threshold code meaning on the pin source: 78 mV per step, 0x80 is 0 V
    localparam logic [7:0] LEVEL_ZERO_CODE = 8'h80;
    localparam logic [7:0] LEVEL_MIN_CODE = 8'h00;
    localparam logic [7:0] LEVEL_MAX_CODE = 8'hFF;
    localparam int LEVEL_STEP_MV = 78;
    localparam int LEVEL_STEPS = 256;
    typedef enum logic [1:0] {
        TSRC_SOFTWARE = 2'h0, TSRC_ANALOG = 2'h1, TSRC_DIGITAL = 2'h2
    } trig_src_t;
    typedef enum logic [2:0] {
        COND_BELOW_LOW = 3'h0, COND_ABOVE_HIGH = 3'h1, COND_INSIDE = 3'h2,
        COND_HIGH_HYST = 3'h3, COND_LOW_HYST = 3'h4
    } cond_t;
    typedef enum logic [1:0] {
        TSEL_INTERNAL = 2'h0, TSEL_AUX0 = 2'h1, TSEL_AUX1 = 2'h2, TSEL_BUS = 2'h3
    } tsel_t;
    typedef enum logic {DISARMED = 1'b0, ARMED = 1'b1} arm_t;
    // values after reset
    localparam trig_src_t RST_SRC = TSRC_SOFTWARE;
    localparam cond_t RST_COND = COND_BELOW_LOW;
    localparam logic [7:0] RST_LEVEL = LEVEL_ZERO_CODE;
    localparam logic RST_ANA_SRC = 1'b0;
    localparam logic [6:0] RST_MASTER = 7'h00;
endpackage
`default_nettype wire

/* File: verification/sync_far_side.sv */
// other boards on the sync bus: wire resolution per line
`timescale 1ns/100ps
`default_nettype none
module sync_far_side (
    input wire logic clk_sys, // board clock
    input wire logic [6:0] board_sync_bus_out, // our drive value
    input wire logic [6:0] board_sync_bus_oe_n, // our enable, low drives
    input wire logic [6:0] far_master, // lines another board drives
    input wire logic [6:0] far_value, // value the other board drives
    output logic [6:0] board_sync_bus_in // resolved line levels
);
    logic [6:0] floating = 7'h00;
    // undriven lines toggle so a stale level is never mistaken for data
    always_ff @(posedge clk_sys) begin
        floating <= ~floating;
    end
    always_comb begin
        for (int i = 0; i < 7; i++) begin
            if (!board_sync_bus_oe_n[i]) begin
                board_sync_bus_in[i] = board_sync_bus_out[i];
            end else if (far_master[i]) begin
                board_sync_bus_in[i] = far_value[i];
            end else begin
                board_sync_bus_in[i] = floating[i];
            end
        end
    end
endmodule
`default_nettype wire

/* File: verification/tb_trigger_timing_route.sv */
// self-checking bench for the trigger select and timing route block
`timescale 1ns/100ps
`default_nettype none
`define CHECK(nm, exp, got) begin samples_checked++; if ((got) !== (exp)) begin \
    bad_count++; $display("BAD %s expected %h seen %h", nm, exp, got); end end
module tb_trigger_timing_route;
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0, rd = 1'b0, cmp_below_low = 1'b0, cmp_above_high = 1'b0;
    logic [1:0] aux_function_inputs = 2'h0;
    logic [6:0] internal_timing = 7'h00, far_master = 7'h00, far_value = 7'h00;
    logic [6:0] board_sync_bus_in, board_sync_bus_out, board_sync_bus_oe_n, timing_sig;
    logic [31:0] rdata, rd_val;
    logic conv_in_trigger, conv_out_trigger, analog_src_sel;
    logic [7:0] low_level_code, high_level_code;
    int bad_count = 0;
    int samples_checked = 0;
    int n_in, n_out, n_both;
    localparam logic [1:0] SS = 2'h0, SA = 2'h1, SD = 2'h2;
    // per condition: idle and qualifying comparator levels
    localparam logic [2:0] IB = 3'h4, IA = 3'h0, QB = 3'h1, QA = 3'h2;
    always #2 clk_sys = ~clk_sys;
    trigger_timing_route u_trigger_timing_route (.clk_sys(clk_sys), .reset(reset),
        .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .cmp_below_low(cmp_below_low), .cmp_above_high(cmp_above_high),
        .aux_function_inputs(aux_function_inputs), .internal_timing(internal_timing),
        .board_sync_bus_in(board_sync_bus_in), .board_sync_bus_out(board_sync_bus_out),
        .board_sync_bus_oe_n(board_sync_bus_oe_n), .timing_sig(timing_sig),
        .conv_in_trigger(conv_in_trigger), .conv_out_trigger(conv_out_trigger),
        .analog_src_sel(analog_src_sel), .low_level_code(low_level_code),
        .high_level_code(high_level_code));
    sync_far_side u_sync_far_side (.clk_sys(clk_sys), .board_sync_bus_out(board_sync_bus_out),
        .board_sync_bus_oe_n(board_sync_bus_oe_n), .far_master(far_master),
        .far_value(far_value), .board_sync_bus_in(board_sync_bus_in));
    function automatic logic [31:0] ctrl(input logic [1:0] si, input logic [1:0] so,
        input logic ana, input logic [2:0] c);
        return {24'h0, c, ana, so, si};
    endfunction
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk_sys);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a);
        @(posedge clk_sys);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk_sys);
        rd <= 1'b0;
        #1 rd_val = rdata;
    endtask
    // counts pulses so a stretched pulse shows as two
    task automatic catch_pulses(input int n);
        n_in = 0;
        n_out = 0;
        n_both = 0;
        repeat (n) begin
            #1;
            if (conv_in_trigger === 1'b1) n_in++;
            if (conv_out_trigger === 1'b1) n_out++;
            if (conv_in_trigger === 1'b1 && conv_out_trigger === 1'b1) n_both++;
            @(posedge clk_sys);
        end
    endtask
    task automatic drive_cmp(input logic b, input logic a);
        @(posedge clk_sys);
        cmp_below_low <= b;
        cmp_above_high <= a;
        catch_pulses(12);
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        #20000;
        bad_count++;
        tally_and_finish;
    end
    initial begin
        repeat (2) @(posedge clk_sys);
        reset <= 1'b0;
        #1 `CHECK("oe_n", 7'h7F, board_sync_bus_oe_n)
        rd_reg(trig_route_pkg::OFS_THRESH);
        `CHECK("thresh", 32'h0000_8080, rd_val)
        rd_reg(8'h20);
        `CHECK("unmapped", 32'h0, rd_val)
        wr_reg(trig_route_pkg::OFS_SW_TRIG, 32'h3);
        catch_pulses(4);
        `CHECK("sw both", 1, n_both)
        wr_reg(trig_route_pkg::OFS_SW_TRIG, 32'h2);
        catch_pulses(4);
        `CHECK("sw out only", 1, n_in * 10 + n_out)
        wr_reg(trig_route_pkg::OFS_TRIG_CTRL, ctrl(SD, SS, 1'b0, 3'h0));
        wr_reg(trig_route_pkg::OFS_SW_TRIG, 32'h3);
        catch_pulses(4);
        `CHECK("sw in refused", 0, n_in + 10 * (n_out - 1))
        @(posedge clk_sys);
        aux_function_inputs <= 2'h1;
        catch_pulses(12);
        `CHECK("dig in only", 1, n_in + 10 * n_out)
        wr_reg(trig_route_pkg::OFS_TRIG_CTRL, ctrl(SA, SA, 1'b1, 3'h0));
        #1 `CHECK("ana src", 1'b1, analog_src_sel)
        wr_reg(trig_route_pkg::OFS_THRESH, 32'h0000_FF00);
        #1 `CHECK("levels", 16'hFF00, {high_level_code, low_level_code})
        for (int c = 0; c < 3; c++) begin
            wr_reg(trig_route_pkg::OFS_TRIG_CTRL, ctrl(SA, SA, 1'b1, c[2:0]));
            drive_cmp(IB[c], IA[c]);
            `CHECK("cond idle", 0, n_in + n_out)
            drive_cmp(QB[c], QA[c]);
            `CHECK("level cond", 3'h7, {n_in == 1, n_out == 1, n_both == 1})
        end
        wr_reg(trig_route_pkg::OFS_TRIG_CTRL, ctrl(SA, SA, 1'b1, 3'h3));
        drive_cmp(1'b0, 1'b0);
        drive_cmp(1'b0, 1'b1);
        `CHECK("hyst unarmed", 0, n_in)
        drive_cmp(1'b1, 1'b0);
        drive_cmp(1'b0, 1'b0);
        drive_cmp(1'b0, 1'b1);
        `CHECK("hyst fire", 2, n_in + n_both)
        drive_cmp(1'b0, 1'b0);
        drive_cmp(1'b0, 1'b1);
        `CHECK("no rearm", 0, n_in)
        wr_reg(trig_route_pkg::OFS_TRIG_CTRL, ctrl(SA, SA, 1'b1, 3'h4));
        drive_cmp(1'b0, 1'b0);
        drive_cmp(1'b0, 1'b1);
        drive_cmp(1'b0, 1'b0);
        drive_cmp(1'b1, 1'b0);
        `CHECK("low hyst", 1, n_out)
        @(posedge clk_sys);
        internal_timing <= 7'h15;
        aux_function_inputs <= 2'h2;
        // line 1 high from a far master, while our own source for it is low
        far_master <= 7'h02;
        far_value <= 7'h02;
        wr_reg(trig_route_pkg::OFS_TIMING_SEL, 32'h0000_006C);
        wr_reg(trig_route_pkg::OFS_MASTER, 32'h0000_0011);
        repeat (8) @(posedge clk_sys);
        #1 `CHECK("timing", 7'h17, timing_sig)
        `CHECK("master", 14'h3711, {board_sync_bus_oe_n, board_sync_bus_out})
        @(posedge clk_sys);
        reset <= 1'b1;
        @(posedge clk_sys);
        reset <= 1'b0;
        #1 `CHECK("rst bus", 14'h3F80, {board_sync_bus_oe_n, board_sync_bus_out})
        rd_reg(trig_route_pkg::OFS_TIMING_SEL);
        `CHECK("rst sel", 32'h0, rd_val)
        tally_and_finish;
    end
endmodule
`default_nettype wire
